// ### logic/tcc_pkg.sv
// Purpose: constants for the channel two/three capture-compare control block
// Assumes: 16-bit registers on a plain strobe port, byte addresses
// Notes:   index 0 is channel two, index 1 is channel three
// Behaviour
// - Mode field writable only while channel disabled
// - Channel three mode codes select input source
// - Channel two mode codes select input source
// - Clear enable forces reference low on trigger
// - Frozen code holds reference level
// - Match sets, clears or toggles reference
// - Codes 100/101 force reference low/high
// - PWM mode 0 active below compare
// - PWM mode 1 inactive below compare
// - PWM level changes only on defined events
// - Compare control locked at top protection
// - Shadow compare value loads at update event
// - Shadow enable locked at top protection
// - Fast enable treats trigger as match
// - Trigger to output 5 or 3 cycles; only the 3-cycle fast path (PWM modes, fast enable) is built
// - Filter changes after N agreeing samples
// - Filter code selects sample rate and N
// - Prescaler captures every 1/2/4/8 edges
// - Prescaler count cleared while channel disabled
// - Input fields overlay compare fields
// - Enable/polarity register bit layout
// - Enable bit gates output or capture
// - Polarity pair selects active edge
package tcc_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0]  ADDR_CTRL      = 8'h1C;
    localparam logic [7:0]  ADDR_ENPOL     = 8'h20;
    localparam logic [7:0]  ADDR_CMP_TWO   = 8'h3C;
    localparam logic [7:0]  ADDR_CMP_THREE = 8'h40;
    localparam logic [7:0]  ADDR_STATUS    = 8'h48;
    localparam logic [15:0] CTRL_RESET     = 16'h0000;
    localparam logic [15:0] ENPOL_RESET    = 16'h0000;
    localparam logic [15:0] ENPOL_RW_MASK  = 16'h3FFF;
    localparam logic [15:0] CMP_RESET      = 16'h0000;

    // ------------------------------------------------------------
    // Control register fields, relative to channel base
    // ------------------------------------------------------------
    localparam int CH_STRIDE   = 8;
    localparam int F_MS_LSB    = 0;
    localparam int F_FAST      = 2;
    localparam int F_SHADOW    = 3;
    localparam int F_CTL_LSB   = 4;
    localparam int F_CLR       = 7;
    localparam int F_PSC_LSB   = 2;
    localparam int F_FLT_LSB   = 4;

    // ------------------------------------------------------------
    // Enable/polarity fields
    // ------------------------------------------------------------
    localparam int EP_BASE     = 8;
    localparam int EP_STRIDE   = 4;
    localparam int EP_EN       = 0;
    localparam int EP_POL      = 1;
    localparam int EP_NPOL     = 3;

    // ------------------------------------------------------------
    // Codes
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        MS_OUTPUT  = 2'b00,
        MS_OWN     = 2'b01,
        MS_NEIGHB  = 2'b10,
        MS_TRIGGER = 2'b11
    } tcc_mode_t;

    typedef enum logic [2:0] {
        OC_FROZEN  = 3'b000,
        OC_SET     = 3'b001,
        OC_CLEAR   = 3'b010,
        OC_TOGGLE  = 3'b011,
        OC_LOW     = 3'b100,
        OC_HIGH    = 3'b101,
        OC_PWM0    = 3'b110,
        OC_PWM1    = 3'b111
    } tcc_ocmode_t;

    localparam logic [1:0] PROTECTION_LEVEL_TOP = 2'b11;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int TRIG_FAST_CYCLES = 3;
    localparam int TRIG_SLOW_CYCLES = 5;

    // Filter length N for each filter code
    function automatic logic [3:0] filt_len(input logic [3:0] code);
        case (code)
            4'h0:    filt_len = 4'h1;
            4'h1:    filt_len = 4'h2;
            4'h2:    filt_len = 4'h4;
            4'hA, 4'hD: filt_len = 4'h5;
            4'h4, 4'h6, 4'h8, 4'hB, 4'hE: filt_len = 4'h6;
            default: filt_len = 4'h8;
        endcase
    endfunction

    // Divider mask of the dead-time tick count for each filter code
    function automatic logic [4:0] filt_div_mask(input logic [3:0] code);
        case (code)
            4'h4, 4'h5: filt_div_mask = 5'h01;
            4'h6, 4'h7: filt_div_mask = 5'h03;
            4'h8, 4'h9: filt_div_mask = 5'h07;
            4'hA, 4'hB, 4'hC: filt_div_mask = 5'h0F;
            4'hD, 4'hE, 4'hF: filt_div_mask = 5'h1F;
            default: filt_div_mask = 5'h00;
        endcase
    endfunction

endpackage

// ### logic/tcc_channel_ctrl.sv
// Purpose: capture/compare control for timer channels two and three
// Assumes: counter, direction, update and trigger events come from the core
// Notes:   read data appears the cycle after the read strobe
`timescale 1ns/1ps
module tcc_channel_ctrl (
    input  wire logic        clock,
    input  wire logic        rstn,
    input  wire logic [7:0]  regAddr,
    input  wire logic [15:0] regWrData,
    input  wire logic        regWrite,
    input  wire logic        regRead,
    output logic      [15:0] regRdData,
    input  wire logic [15:0] counterValue,
    input  wire logic        countingDown,
    input  wire logic        updateEvent,
    input  wire logic        triggerEdge,
    input  wire logic        externalTriggerFiltered,
    input  wire logic        internalTriggerSelected,
    input  wire logic        internalTrigger,
    input  wire logic [1:0]  protectionLevel,
    input  wire logic        deadTimeSampleTick,
    input  wire logic [1:0]  chanPinInput,
    output logic      [1:0]  chanOutputReference,
    output logic      [1:0]  chanPinOutput,
    output logic      [1:0]  chanCapturePulse
);

    // ------------------------------------------------------------
    // Registers and shared state
    // ------------------------------------------------------------
    logic [15:0] ctrl_reg;
    logic [15:0] ctrl_next;
    logic [15:0] enpol_reg;
    logic [15:0] rdData_reg;
    logic [15:0] status;
    logic [15:0] ctrlKeep;
    localparam int TRIG_FAST_CYCLES_W = tcc_pkg::TRIG_FAST_CYCLES - 1;
    logic [4:0]  dtsDiv_reg;
    logic [TRIG_FAST_CYCLES_W-1:0] trigPipe_reg;
    logic [1:0]  filtOut;
    logic [15:0] cmpView [2];

    // ------------------------------------------------------------
    // Control register write with per-field locks
    // ------------------------------------------------------------
    assign ctrl_next = (regWrData & ~ctrlKeep) | (ctrl_reg & ctrlKeep);

    always_ff @(posedge clock) begin
        if (!rstn) begin
            ctrl_reg <= tcc_pkg::CTRL_RESET;
        end else if (regWrite && regAddr == tcc_pkg::ADDR_CTRL) begin
            ctrl_reg <= ctrl_next;
        end
    end

    // Reserved bits 15:14 stay at reset value
    always_ff @(posedge clock) begin
        if (!rstn) begin
            enpol_reg <= tcc_pkg::ENPOL_RESET;
        end else if (regWrite && regAddr == tcc_pkg::ADDR_ENPOL) begin
            enpol_reg <= regWrData & tcc_pkg::ENPOL_RW_MASK;
        end
    end

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    assign status = {12'h000, filtOut, chanOutputReference};

    always_ff @(posedge clock) begin
        if (!rstn || !regRead) begin
            rdData_reg <= 16'h0000;
        end else begin
            case (regAddr)
                tcc_pkg::ADDR_CTRL:      rdData_reg <= ctrl_reg;
                tcc_pkg::ADDR_ENPOL:     rdData_reg <= enpol_reg;
                tcc_pkg::ADDR_CMP_TWO:   rdData_reg <= cmpView[0];
                tcc_pkg::ADDR_CMP_THREE: rdData_reg <= cmpView[1];
                tcc_pkg::ADDR_STATUS:    rdData_reg <= status;
                default:                 rdData_reg <= 16'h0000;
            endcase
        end
    end

    assign regRdData = rdData_reg;

    // ------------------------------------------------------------
    // Dead-time tick divider and trigger pipeline
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!rstn) begin
            dtsDiv_reg <= 5'h00;
        end else if (deadTimeSampleTick) begin
            dtsDiv_reg <= dtsDiv_reg + 5'h01;
        end
    end

    // Fast path: edge, two stages, reference flop gives the third cycle
    always_ff @(posedge clock) begin
        if (!rstn) begin
            trigPipe_reg <= '0;
        end else begin
            trigPipe_reg <= {trigPipe_reg[TRIG_FAST_CYCLES_W-2:0], triggerEdge};
        end
    end

    // ------------------------------------------------------------
    // Per-channel logic
    // ------------------------------------------------------------
    for (genvar i = 0; i < 2; i++) begin : g_chan
        localparam int CB = i * tcc_pkg::CH_STRIDE;
        localparam int EB = tcc_pkg::EP_BASE + i * tcc_pkg::EP_STRIDE;
        localparam logic [7:0] CMP_ADDR = (i == 0) ? tcc_pkg::ADDR_CMP_TWO : tcc_pkg::ADDR_CMP_THREE;

        logic [1:0]  modeSel;
        logic [2:0]  cmpCtrl;
        logic [3:0]  filtCode;
        logic [1:0]  pscCode;
        logic        clearEn, shadowEn, fastEn, chanEn, pol, npol, locked;
        logic        sampleStb, srcLevel, activeEdge, isPwm, match, pwmLevel, cmpWrite;
        logic [3:0]  filtCnt_reg;
        logic        filtOut_reg;
        logic        srcPrev_reg;
        logic [2:0]  pscCnt_reg;
        logic [2:0]  pscMask;
        logic        capPulse_reg;
        logic [15:0] cmpActive_reg;
        logic [15:0] cmpShadow_reg;
        logic        ref_reg;
        logic        pinOut_reg;
        logic [2:0]  prevCtrl_reg;
        logic        prevPwm_reg;

        // Input fields overlay the compare fields
        assign modeSel  = ctrl_reg[CB + tcc_pkg::F_MS_LSB +: 2];
        assign cmpCtrl  = ctrl_reg[CB + tcc_pkg::F_CTL_LSB +: 3];
        assign clearEn  = ctrl_reg[CB + tcc_pkg::F_CLR];
        assign shadowEn = ctrl_reg[CB + tcc_pkg::F_SHADOW];
        assign fastEn   = ctrl_reg[CB + tcc_pkg::F_FAST];
        assign filtCode = ctrl_reg[CB + tcc_pkg::F_FLT_LSB +: 4];
        assign pscCode  = ctrl_reg[CB + tcc_pkg::F_PSC_LSB +: 2];
        assign chanEn   = enpol_reg[EB + tcc_pkg::EP_EN];
        assign pol      = enpol_reg[EB + tcc_pkg::EP_POL];
        // Channel three has no complementary polarity bit
        assign npol     = (i == 0) ? enpol_reg[EB + tcc_pkg::EP_NPOL] : 1'b0;

        // Write locks on the control fields
        assign locked = (protectionLevel == tcc_pkg::PROTECTION_LEVEL_TOP) && (modeSel == tcc_pkg::MS_OUTPUT);
        assign ctrlKeep[CB + tcc_pkg::F_MS_LSB +: 2]  = {2{chanEn}};
        assign ctrlKeep[CB + tcc_pkg::F_FAST]         = 1'b0;
        assign ctrlKeep[CB + tcc_pkg::F_SHADOW]       = locked;
        assign ctrlKeep[CB + tcc_pkg::F_CTL_LSB +: 3] = {3{locked}};
        assign ctrlKeep[CB + tcc_pkg::F_CLR]          = 1'b0;

        // ---------------- Input filter ----------------
        always_comb begin
            if (filtCode == 4'h0) begin
                sampleStb = deadTimeSampleTick;
            end else if (filtCode <= 4'h3) begin
                sampleStb = 1'b1;
            end else begin
                sampleStb = deadTimeSampleTick &&
                    ((dtsDiv_reg & tcc_pkg::filt_div_mask(filtCode)) == tcc_pkg::filt_div_mask(filtCode));
            end
        end

        // A disagreeing sample restarts the run
        always_ff @(posedge clock) begin
            if (!rstn) begin
                filtCnt_reg <= 4'h0;
                filtOut_reg <= 1'b0;
            end else if (sampleStb) begin
                if (chanPinInput[i] == filtOut_reg) begin
                    filtCnt_reg <= 4'h0;
                end else if (filtCnt_reg + 4'h1 >= tcc_pkg::filt_len(filtCode)) begin
                    filtCnt_reg <= 4'h0;
                    filtOut_reg <= chanPinInput[i];
                end else begin
                    filtCnt_reg <= filtCnt_reg + 4'h1;
                end
            end
        end

        assign filtOut[i] = filtOut_reg;

        // ---------------- Source and edge ----------------
        always_comb begin
            case (modeSel)
                tcc_pkg::MS_OWN:     srcLevel = filtOut[i];
                tcc_pkg::MS_NEIGHB:  srcLevel = filtOut[1 - i];
                tcc_pkg::MS_TRIGGER: srcLevel = internalTriggerSelected && internalTrigger;
                default:             srcLevel = 1'b0;
            endcase
        end

        always_ff @(posedge clock) begin
            if (!rstn) begin
                srcPrev_reg <= 1'b0;
            end else begin
                srcPrev_reg <= srcLevel;
            end
        end

        // Reserved pair {1,0} yields no edge
        always_comb begin
            case ({npol, pol})
                2'b00:   activeEdge = srcLevel && !srcPrev_reg;
                2'b01:   activeEdge = !srcLevel && srcPrev_reg;
                2'b11:   activeEdge = srcLevel != srcPrev_reg;
                default: activeEdge = 1'b0;
            endcase
        end

        // ---------------- Capture prescaler ----------------
        assign pscMask = (3'h1 << pscCode) - 3'h1;

        always_ff @(posedge clock) begin
            if (!rstn) begin
                pscCnt_reg   <= 3'h0;
                capPulse_reg <= 1'b0;
            end else if (!chanEn) begin
                pscCnt_reg   <= 3'h0;
                capPulse_reg <= 1'b0;
            end else if (modeSel != tcc_pkg::MS_OUTPUT && activeEdge) begin
                capPulse_reg <= (pscCnt_reg & pscMask) == pscMask;
                pscCnt_reg   <= ((pscCnt_reg & pscMask) == pscMask) ? 3'h0 : pscCnt_reg + 3'h1;
            end else begin
                capPulse_reg <= 1'b0;
            end
        end

        assign chanCapturePulse[i] = capPulse_reg;

        // ---------------- Compare value ----------------
        assign cmpWrite = regWrite && regAddr == CMP_ADDR && modeSel == tcc_pkg::MS_OUTPUT;

        always_ff @(posedge clock) begin
            if (!rstn) begin
                cmpShadow_reg <= tcc_pkg::CMP_RESET;
            end else if (cmpWrite) begin
                cmpShadow_reg <= regWrData;
            end
        end

        // Capture shares the active register, read-only in input mode
        always_ff @(posedge clock) begin
            if (!rstn) begin
                cmpActive_reg <= tcc_pkg::CMP_RESET;
            end else if (modeSel != tcc_pkg::MS_OUTPUT) begin
                if (chanEn && activeEdge && (pscCnt_reg & pscMask) == pscMask) begin
                    cmpActive_reg <= counterValue;
                end
            end else if (cmpWrite && !shadowEn) begin
                cmpActive_reg <= regWrData;
            end else if (shadowEn && updateEvent) begin
                cmpActive_reg <= cmpShadow_reg;
            end
        end

        assign cmpView[i] = cmpActive_reg;

        // ---------------- Output reference ----------------
        assign match = counterValue == cmpActive_reg;
        assign isPwm = cmpCtrl == tcc_pkg::OC_PWM0 || cmpCtrl == tcc_pkg::OC_PWM1;

        always_comb begin
            pwmLevel = countingDown ? !(counterValue > cmpActive_reg) : counterValue < cmpActive_reg;
            if (cmpCtrl == tcc_pkg::OC_PWM1) begin
                pwmLevel = !pwmLevel;
            end
        end

        always_ff @(posedge clock) begin
            if (!rstn) begin
                prevCtrl_reg <= tcc_pkg::OC_FROZEN;
                prevPwm_reg  <= 1'b0;
            end else begin
                prevCtrl_reg <= cmpCtrl;
                prevPwm_reg  <= pwmLevel;
            end
        end

        always_ff @(posedge clock) begin
            if (!rstn) begin
                ref_reg <= 1'b0;
            end else if (clearEn && externalTriggerFiltered) begin
                ref_reg <= 1'b0;
            end else if (isPwm && fastEn && trigPipe_reg[TRIG_FAST_CYCLES_W-1]) begin
                // Level a match would give while counting up
                ref_reg <= cmpCtrl == tcc_pkg::OC_PWM1;
            end else begin
                case (cmpCtrl)
                    tcc_pkg::OC_FROZEN: ref_reg <= ref_reg;
                    tcc_pkg::OC_SET:    if (match) ref_reg <= 1'b1;
                    tcc_pkg::OC_CLEAR:  if (match) ref_reg <= 1'b0;
                    tcc_pkg::OC_TOGGLE: if (match) ref_reg <= !ref_reg;
                    tcc_pkg::OC_LOW:    ref_reg <= 1'b0;
                    tcc_pkg::OC_HIGH:   ref_reg <= 1'b1;
                    tcc_pkg::OC_PWM0,
                    tcc_pkg::OC_PWM1: begin
                        if (prevCtrl_reg == tcc_pkg::OC_FROZEN || pwmLevel != prevPwm_reg) begin
                            ref_reg <= pwmLevel;
                        end
                    end
                    default:            ref_reg <= ref_reg;
                endcase
            end
        end

        assign chanOutputReference[i] = ref_reg;

        // Pin output: polarity applied, driven only when enabled as output
        always_ff @(posedge clock) begin
            if (!rstn) begin
                pinOut_reg <= 1'b0;
            end else begin
                pinOut_reg <= chanEn && modeSel == tcc_pkg::MS_OUTPUT && (ref_reg ^ pol);
            end
        end

        assign chanPinOutput[i] = pinOut_reg;
    end

endmodule // tcc_channel_ctrl

// ### dv/tcc_props.sv
// Purpose: port-level checks of the channel control block
// Assumes: enable and clear bits follow the bus writes
// Notes:   bound into every instance of the block
`timescale 1ns/1ps
module tcc_props (
    input wire logic        clock,
    input wire logic        rstn,
    input wire logic [7:0]  regAddr,
    input wire logic [15:0] regWrData,
    input wire logic        regWrite,
    input wire logic        regRead,
    input wire logic [15:0] regRdData,
    input wire logic        externalTriggerFiltered,
    input wire logic [1:0]  chanOutputReference,
    input wire logic [1:0]  chanPinOutput,
    input wire logic [1:0]  chanCapturePulse
);
    logic [15:0] enpolReg;
    logic [1:0]  clrReg;
    // Clear bits are never refused, so a plain copy is exact
    always_ff @(posedge clock) begin
        if (!rstn) begin
            enpolReg <= tcc_pkg::ENPOL_RESET;
            clrReg   <= 2'b00;
        end else if (regWrite && regAddr == tcc_pkg::ADDR_ENPOL) begin
            enpolReg <= regWrData & tcc_pkg::ENPOL_RW_MASK;
        end else if (regWrite && regAddr == tcc_pkg::ADDR_CTRL) begin
            clrReg <= {regWrData[15], regWrData[7]};
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    sequence enpolRead;
        $past(regRead) && $past(regAddr) == tcc_pkg::ADDR_ENPOL;
    endsequence
    sequence twoOff;
        (!enpolReg[8]) [*3];
    endsequence
    sequence threeOff;
        (!enpolReg[12]) [*3];
    endsequence
    read_idle_zero_a: assert property (!$past(regRead) |-> regRdData == 16'h0000) else $error("read data not idle");
    reserved_bits_zero_a: assert property (enpolRead |-> regRdData[15:14] == 2'b00) else $error("reserved bits set");
    enpol_readback_a: assert property (enpolRead |-> regRdData == $past(enpolReg)) else $error("enable read wrong");
    cap_gate_two_a: assert property (twoOff |=> !chanCapturePulse[0]) else $error("capture while off");
    cap_gate_three_a: assert property (threeOff |=> !chanCapturePulse[1]) else $error("capture while off");
    pin_off_two_a: assert property ((!enpolReg[8]) [*2] |=> !chanPinOutput[0]) else $error("pin on while off");
    pin_off_three_a: assert property ((!enpolReg[12]) [*2] |=> !chanPinOutput[1]) else $error("pin on while off");
    clear_low_two_a: assert property (clrReg[0] && externalTriggerFiltered |=> !chanOutputReference[0])
        else $error("clear not low");
    clear_low_three_a: assert property (clrReg[1] && externalTriggerFiltered |=> !chanOutputReference[1])
        else $error("clear not low");
endmodule // tcc_props

bind tcc_channel_ctrl tcc_props i_tcc_props (.*);

// ### dv/tcc_core_model.sv
// Purpose: counter core model feeding the channel block
// Assumes: fixed period, update event on each wrap
// Notes:   dead-time tick every second cycle
`timescale 1ns/1ps
module tcc_core_model #(
    parameter int PERIOD = 32
) (
    input  wire logic        clock,
    input  wire logic        rstn,
    input  wire logic        down,
    output logic      [15:0] counterValue,
    output logic             countingDown,
    output logic             updateEvent,
    output logic             deadTimeSampleTick
);
    localparam logic [15:0] TOP = 16'(PERIOD - 1);
    always_ff @(posedge clock) begin
        if (!rstn) begin
            counterValue       <= 16'h0000;
            updateEvent        <= 1'b0;
            deadTimeSampleTick <= 1'b0;
        end else begin
            deadTimeSampleTick <= !deadTimeSampleTick;
            if (down) begin
                counterValue <= (counterValue == 16'h0000) ? TOP : counterValue - 16'h0001;
            end else begin
                counterValue <= (counterValue == TOP) ? 16'h0000 : counterValue + 16'h0001;
            end
            updateEvent <= down ? (counterValue == 16'h0001) : (counterValue == TOP - 16'h0001);
        end
    end
    assign countingDown = down;
endmodule // tcc_core_model

// ### dv/timer_channel_two_three_control_tb.sv
// Purpose: self-checking bench of the channel control block
// Assumes: core model counts 0..31, compare of channel two is 10
// Notes:   bus reads are checked from a queue at the falling edge
`timescale 1ns/1ps
module timer_channel_two_three_control_tb;
    logic        clock, rstn, regWrite, regRead, rdSeen, triggerEdge, down;
    logic        externalTriggerFiltered, internalTriggerSelected, internalTrigger;
    logic [7:0]  regAddr;
    logic [15:0] regWrData, regRdData, counterValue, v;
    logic [1:0]  protectionLevel, chanPinInput, chanOutputReference, chanPinOutput, chanCapturePulse;
    logic        countingDown, updateEvent, deadTimeSampleTick;
    logic [31:0] note, e, expQ[$];
    int          fails, totalChecks, capCount, base, cycles;
    // {down, code} / expected ref / counter value at the look
    localparam logic [15:0] CMP_TAB [16] = '{16'h1114, 16'h2014, 16'h3114, 16'h3014, 16'h5114, 16'h0114,
        16'h4014, 16'h0014, 16'h7114, 16'h7005, 16'h6105, 16'h6014, 16'hE014, 16'hE105, 16'hF114, 16'hF005};
    // {pol pair, prescaler, filter} / pulse width / pulses / captures
    localparam logic [31:0] CAP_TAB [11] = '{32'h00040808, 32'h10040804, 32'h20040802, 32'h30040801,
        32'hC0040810, 32'h40040808, 32'h03040800, 32'h030C0808, 32'h30040400, 32'h30040400, 32'h0FFF0100};
    tcc_channel_ctrl i_tcc_channel_ctrl (.*);
    tcc_core_model i_tcc_core_model (.*);
    always #2.5 clock = ~clock;
    always @(posedge clock) rdSeen <= regRead;
    always @(posedge clock) if (chanCapturePulse[0] === 1'b1) capCount <= capCount + 1;
    always @(negedge clock) begin
        if (rdSeen === 1'b1) begin
            note = expQ.pop_front();
            totalChecks++;
            if ((regRdData & note[31:16]) !== note[15:0]) begin
                fails++;
                $display("ERROR %0t: read %h expected %h", $time, regRdData, note[15:0]);
            end
        end
    end
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails++;
            $display("ERROR %0t: run too long", $time);
            wrap_up();
        end
    end
    task automatic chk(input logic ok, input string what);
        totalChecks++;
        if (ok !== 1'b1) begin
            fails++;
            $display("ERROR %0t: %s", $time, what);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        regAddr <= a;
        regWrData <= d;
        regWrite <= 1'b1;
        @(posedge clock);
        regWrite <= 1'b0;
        @(posedge clock);
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] m, input logic [15:0] x);
        expQ.push_back({m, x & m});
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clock);
        regRead <= 1'b0;
        @(posedge clock);
    endtask
    task automatic waitCnt(input logic [7:0] c);
        while (counterValue !== {8'h00, c}) @(posedge clock);
    endtask
    task automatic chkRef(input int n, input logic x);
        repeat (n) @(posedge clock);
        @(negedge clock);
        chk(chanOutputReference[0] === x, "reference level");
        @(posedge clock);
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", totalChecks, fails);
        if (fails == 0 && totalChecks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        clock = 1'b0; rstn = 1'b0; regWrite = 1'b0; regRead = 1'b0; rdSeen = 1'b0; regAddr = 8'h00;
        regWrData = 16'h0000; triggerEdge = 1'b0; externalTriggerFiltered = 1'b0; down = 1'b0; protectionLevel = 2'b00;
        chanPinInput = 2'b00; fails = 0; totalChecks = 0; capCount = 0; cycles = 0; internalTrigger = 1'b0;
        internalTriggerSelected = 1'b0;
        void'($urandom(38));
        repeat (10) @(posedge clock);
        rstn <= 1'b1;
        @(posedge clock);
        rd(tcc_pkg::ADDR_CTRL, 16'hFFFF, tcc_pkg::CTRL_RESET);
        rd(tcc_pkg::ADDR_ENPOL, 16'hFFFF, tcc_pkg::ENPOL_RESET);
        rd(tcc_pkg::ADDR_CMP_TWO, 16'hFFFF, tcc_pkg::CMP_RESET);
        rd(8'h50, 16'hFFFF, 16'h0000);
        repeat (4) begin
            v = 16'($urandom);
            wr(tcc_pkg::ADDR_ENPOL, v);
            rd(tcc_pkg::ADDR_ENPOL, 16'hFFFF, v & tcc_pkg::ENPOL_RW_MASK);
        end
        wr(tcc_pkg::ADDR_ENPOL, 16'h1100);
        wr(tcc_pkg::ADDR_CTRL, 16'h0303);
        rd(tcc_pkg::ADDR_CTRL, 16'h0303, 16'h0000);
        wr(tcc_pkg::ADDR_ENPOL, 16'h0000);
        for (int m = 0; m < 4; m++) begin
            wr(tcc_pkg::ADDR_CTRL, {6'h00, 2'(m), 6'h00, 2'(m)});
            rd(tcc_pkg::ADDR_CTRL, 16'h0303, {6'h00, 2'(m), 6'h00, 2'(m)});
        end
        $display("test registers done");
        wr(tcc_pkg::ADDR_CTRL, 16'h0000);
        wr(tcc_pkg::ADDR_CMP_TWO, 16'h000A);
        wr(tcc_pkg::ADDR_ENPOL, 16'h0100);
        for (int i = 0; i < 16; i++) begin
            down <= CMP_TAB[i][15];
            wr(tcc_pkg::ADDR_CTRL, {9'h000, CMP_TAB[i][14:12], 4'h0});
            waitCnt(CMP_TAB[i][7:0]);
            chkRef(0, CMP_TAB[i][8]);
            chk(chanPinOutput[0] === CMP_TAB[i][8], "pin level");
        end
        down <= 1'b0;
        $display("test compare modes done");
        wr(tcc_pkg::ADDR_CTRL, 16'h00D0);
        externalTriggerFiltered <= 1'b1;
        chkRef(3, 1'b0);
        externalTriggerFiltered <= 1'b0;
        chkRef(3, 1'b1);
        protectionLevel <= 2'b11;
        wr(tcc_pkg::ADDR_CTRL, 16'h0048);
        rd(tcc_pkg::ADDR_CTRL, 16'h00F8, 16'h0050);
        chkRef(2, 1'b1);
        protectionLevel <= 2'b00;
        $display("test clear and lock done");
        wr(tcc_pkg::ADDR_CTRL, 16'h0078);
        waitCnt(8'h03);
        wr(tcc_pkg::ADDR_CMP_TWO, 16'h0019);
        rd(tcc_pkg::ADDR_CMP_TWO, 16'hFFFF, 16'h000A);
        waitCnt(8'h02);
        rd(tcc_pkg::ADDR_CMP_TWO, 16'hFFFF, 16'h0019);
        $display("test shadow done");
        wr(tcc_pkg::ADDR_CTRL, 16'h007C);
        waitCnt(8'h02);
        triggerEdge <= 1'b1;
        @(posedge clock);
        triggerEdge <= 1'b0;
        chkRef(1, 1'b0);
        chkRef(0, 1'b1);
        $display("test fast trigger done");
        for (int i = 0; i < 11; i++) begin
            e = CAP_TAB[i];
            wr(tcc_pkg::ADDR_ENPOL, 16'h0000);
            wr(tcc_pkg::ADDR_CTRL, {8'h00, e[27:24], e[29:28], 2'b01});
            rd(tcc_pkg::ADDR_CTRL, 16'hFFFF, {8'h00, e[27:24], e[29:28], 2'b01});
            wr(tcc_pkg::ADDR_ENPOL, {4'h0, e[31], 1'b0, e[30], 1'b1, 8'h00});
            base = capCount;
            repeat (e[15:8]) begin
                chanPinInput[0] <= 1'b1;
                repeat (e[23:16]) @(posedge clock);
                chanPinInput[0] <= 1'b0;
                repeat (e[23:16]) @(posedge clock);
            end
            repeat (20) @(posedge clock);
            chk(capCount - base == e[7:0], "capture count");
        end
        $display("test capture done");
        wrap_up();
    end
endmodule // timer_channel_two_three_control_tb
